// ==== src/isrf_params.svh ====
// offsets, field positions, reset values for the split result block
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef ISRF_PARAMS_SVH
`define ISRF_PARAMS_SVH

// register byte offsets
`define ISRF_OFF_SPLIT_SEL   8'h00
`define ISRF_OFF_CTRL        8'h04
`define ISRF_OFF_RESULT_STAT 8'h08
`define ISRF_OFF_SUMMARY     8'h0C
`define ISRF_OFF_COUNT_W7LO  8'h10
`define ISRF_OFF_COUNT_W7HI  8'h14
`define ISRF_OFF_COUNT_W5HI  8'h18
`define ISRF_OFF_IRQ_STATUS  8'h1C
`define ISRF_OFF_IRQ_MASK    8'h20

// field positions
`define ISRF_POS_CS_SEL      8
`define ISRF_POS_FRAME       8
`define ISRF_POS_STATUS0     8
`define ISRF_POS_XERR_SUM    28
`define ISRF_POS_BABBLE_SUM  29
`define ISRF_POS_W5_SLOT0    8

// status bit positions inside a slot result
`define ISRF_STS_XERR        0
`define ISRF_STS_BABBLE      1
`define ISRF_STS_UNDERRUN    2

// interrupt event bits
`define ISRF_IRQ_DONE        0
`define ISRF_IRQ_XERR        1
`define ISRF_IRQ_BABBLE      2
`define ISRF_IRQ_UNDERRUN    3

// reset values
`define ISRF_RST_SEL         8'h00
`define ISRF_RST_IRQ         4'h0
`define ISRF_RST_FRAME       5'h00

`endif

// ==== src/isrf_pkg.sv ====
// types shared by the split result block, the engine stand-in and the bench
// assumes nothing beyond a systemverilog compiler
package isrf_pkg;

   // one result from the transfer engine
   typedef struct packed {
      logic [2:0] slot;
      logic       is_complete;
      logic [7:0] bytes;
      logic       xerr;
      logic       babble;
      logic       underrun;
   } isrf_result_t;

   // one stored slot entry: status over byte count
   typedef struct packed {
      logic [2:0] status;
      logic [7:0] bytes;
   } isrf_entry_t;

   // microframe tick from the frame timer
   typedef struct packed {
      logic [2:0] uframe;
      logic [4:0] frame;
   } isrf_tick_t;

endpackage

// ==== src/isrf_slot_store.sv ====
// per-slot store of byte count and status, one write port
// assumes writes come from logic on the same clock
module isrf_slot_store #(
   parameter int DEPTH = 8,
   parameter int WIDTH = 11
) (
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_resetn,
   input  wire logic                     i_we,
   input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
   input  wire logic [WIDTH-1:0]         i_wdata,
   output logic      [DEPTH*WIDTH-1:0]   o_rdata_all
);

   logic [DEPTH*WIDTH-1:0] mem_reg;
   logic [DEPTH*WIDTH-1:0] mem_next;

   // next contents: only the addressed entry changes
   always_comb begin
      mem_next = mem_reg;
      if (i_we) begin
         mem_next[i_waddr*WIDTH +: WIDTH] = i_wdata;
      end
   end

   // register the contents
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         mem_reg <= '0;
      end else begin
         mem_reg <= mem_next;
      end
   end

   assign o_rdata_all = mem_reg;

endmodule

// ==== src/isrf_top.sv ====
// split interrupt result fields: schedule bits, slot results, summary
// assumes engine inputs are on i_ref_clk; registers over classic wishbone
module isrf_top (
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_resetn,
   input  wire logic                  i_wb_cyc,
   input  wire logic                  i_wb_stb,
   input  wire logic                  i_wb_we,
   input  wire logic [7:0]            i_wb_adr,
   input  wire logic [3:0]            i_wb_sel,
   input  wire logic [31:0]           i_wb_dat,
   output logic      [31:0]           o_wb_dat,
   output logic                       o_wb_ack,
   input  wire logic                  i_uframe_tick,
   input  wire isrf_pkg::isrf_tick_t  i_tick,
   input  wire logic                  i_result_valid,
   input  wire isrf_pkg::isrf_result_t i_result,
   output logic                       o_ss_issue,
   output logic                       o_cs_issue,
   output logic      [2:0]            o_issue_slot,
   output logic                       o_irq
);

`include "isrf_params.svh"

   localparam int NSLOT = 8;
   localparam int EW    = 11;

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0]  ss_sel_reg, ss_sel_next;
   logic [7:0]  cs_sel_reg, cs_sel_next;
   logic        dir_in_reg, dir_in_next;
   logic [4:0]  frame_reg, frame_next;
   logic [7:0]  issued_reg, issued_next;
   logic [3:0]  irq_sts_reg, irq_sts_next;
   logic [3:0]  irq_msk_reg, irq_msk_next;
   logic        babble_sum_reg, babble_sum_next;
   logic        xerr_sum_reg, xerr_sum_next;
   logic        ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic        ss_iss_reg, ss_iss_next;
   logic        cs_iss_reg, cs_iss_next;
   logic [2:0]  slot_reg, slot_next;
   logic        irq_reg, irq_next;

   logic [NSLOT*EW-1:0]  store_q;
   logic                 rec;
   isrf_pkg::isrf_entry_t rec_entry;
   logic                 bus_req, bus_wr, bus_rd;
   logic [7:0]           ss_sw_set, cs_sw_set;
   logic [7:0]           ss_hw_clr, cs_hw_clr;
   logic                 frame_ok;
   logic [7:0]           any_babble, any_xerr;

   // byte count of one slot from the flat store
   function automatic logic [7:0] slot_bytes(
      input logic [NSLOT*EW-1:0] q,
      input int                  k
   );
      isrf_pkg::isrf_entry_t e;
      e = q[k*EW +: EW];
      return e.bytes;
   endfunction

   // status of one slot from the flat store
   function automatic logic [2:0] slot_status(
      input logic [NSLOT*EW-1:0] q,
      input int                  k
   );
      isrf_pkg::isrf_entry_t e;
      e = q[k*EW +: EW];
      return e.status;
   endfunction

   // one flag of one slot's status from the flat store
   function automatic logic slot_flag(
      input logic [NSLOT*EW-1:0] q,
      input int                  k,
      input int                  b
   );
      logic [2:0] s;
      s = slot_status(q, k);
      return s[b];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // slot results live in their own store
   isrf_slot_store #(
      .DEPTH (NSLOT),
      .WIDTH (EW)
   ) u_store (
      .i_ref_clk   (i_ref_clk),
      .i_resetn    (i_resetn),
      .i_we        (rec),
      .i_waddr     (i_result.slot),
      .i_wdata     (rec_entry),
      .o_rdata_all (store_q)
   );

   // record only for a slot with a split in flight, final phase only
   always_comb begin
      rec = i_result_valid && issued_reg[i_result.slot] &&
            (i_result.is_complete || !dir_in_reg);
      rec_entry.bytes = i_result.bytes;
      rec_entry.status[`ISRF_STS_XERR]     = i_result.xerr;
      rec_entry.status[`ISRF_STS_BABBLE]   = i_result.babble &&
                                             dir_in_reg;
      rec_entry.status[`ISRF_STS_UNDERRUN] = i_result.underrun &&
                                             !dir_in_reg;
   end

   ////////////////////////////////////////////////////////////////////////
   // bus decode and schedule bit updates
   always_comb begin
      bus_req  = i_wb_cyc && i_wb_stb && !ack_reg;
      bus_wr   = bus_req && i_wb_we;
      bus_rd   = bus_req && !i_wb_we;
      frame_ok = (i_tick.frame == frame_reg);
      ss_sw_set = '0;
      cs_sw_set = '0;
      if (bus_wr && i_wb_adr == `ISRF_OFF_SPLIT_SEL) begin
         ss_sw_set = i_wb_sel[0] ? i_wb_dat[7:0] : 8'h00;
         cs_sw_set = i_wb_sel[1] ? i_wb_dat[15:8] : 8'h00;
      end
      ss_hw_clr = '0;
      cs_hw_clr = '0;
      if (i_result_valid && !i_result.is_complete) begin
         ss_hw_clr[i_result.slot] = 1'b1;
      end
      // complete result clears the microframe of the last issued split
      if (i_result_valid && i_result.is_complete) begin
         cs_hw_clr[slot_reg] = 1'b1;
      end
      // set wins over clear on the same bit
      ss_sel_next = (ss_sel_reg & ~ss_hw_clr) | ss_sw_set;
      cs_sel_next = (cs_sel_reg & ~cs_hw_clr) | cs_sw_set;
      dir_in_next = dir_in_reg;
      frame_next  = frame_reg;
      if (bus_wr && i_wb_adr == `ISRF_OFF_CTRL) begin
         if (i_wb_sel[0]) begin
            dir_in_next = i_wb_dat[0];
         end
         if (i_wb_sel[1]) begin
            frame_next = i_wb_dat[`ISRF_POS_FRAME +: 5];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // split issue at each microframe tick
   always_comb begin
      ss_iss_next = 1'b0;
      cs_iss_next = 1'b0;
      slot_next   = slot_reg;
      issued_next = issued_reg;
      if (rec) begin
         issued_next[i_result.slot] = 1'b0;
      end
      if (i_uframe_tick) begin
         if (ss_sel_reg[i_tick.uframe] && frame_ok) begin
            ss_iss_next = 1'b1;
            slot_next   = i_tick.uframe;
            issued_next[i_tick.uframe] = 1'b1;
         end else if (cs_sel_reg[i_tick.uframe] && dir_in_reg) begin
            cs_iss_next = 1'b1;
            slot_next   = i_tick.uframe;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // summary flags over all slots
   generate
      for (genvar k = 0; k < NSLOT; k++) begin : g_sum
         assign any_babble[k] = slot_flag(store_q, k, `ISRF_STS_BABBLE);
         assign any_xerr[k]   = slot_flag(store_q, k, `ISRF_STS_XERR);
      end
   endgenerate

   always_comb begin
      babble_sum_next = |any_babble;
      xerr_sum_next   = |any_xerr;
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status, mask, read data and ack
   always_comb begin
      logic [3:0] ev;
      logic [3:0] clr;
      ev  = '0;
      clr = '0;
      ev[`ISRF_IRQ_DONE]     = rec;
      ev[`ISRF_IRQ_XERR]     = rec && rec_entry.status[`ISRF_STS_XERR];
      ev[`ISRF_IRQ_BABBLE]   = rec && rec_entry.status[`ISRF_STS_BABBLE];
      ev[`ISRF_IRQ_UNDERRUN] = rec &&
                               rec_entry.status[`ISRF_STS_UNDERRUN];
      clr = (bus_rd && i_wb_adr == `ISRF_OFF_IRQ_STATUS) ?
            irq_sts_reg : 4'h0;
      irq_sts_next = (irq_sts_reg & ~clr) | ev;
      irq_msk_next = irq_msk_reg;
      if (bus_wr && i_wb_adr == `ISRF_OFF_IRQ_MASK && i_wb_sel[0]) begin
         irq_msk_next = i_wb_dat[3:0];
      end
      irq_next = |(irq_sts_next & irq_msk_next);
      ack_next = bus_req;
      rdat_next = rdat_reg;
      if (bus_rd) begin
         rdat_next = 32'h0000_0000;
         unique case (i_wb_adr)
            `ISRF_OFF_SPLIT_SEL: begin
               rdat_next[7:0] = ss_sel_reg;
               rdat_next[`ISRF_POS_CS_SEL +: 8] = cs_sel_reg;
            end
            `ISRF_OFF_CTRL: begin
               rdat_next[0] = dir_in_reg;
               rdat_next[`ISRF_POS_FRAME +: 5] = frame_reg;
            end
            `ISRF_OFF_RESULT_STAT: begin
               for (int k = 0; k < NSLOT; k++) begin
                  rdat_next[`ISRF_POS_STATUS0 + 3*k +: 3] =
                     slot_status(store_q, k);
               end
            end
            `ISRF_OFF_SUMMARY: begin
               rdat_next[`ISRF_POS_BABBLE_SUM] = babble_sum_reg;
               rdat_next[`ISRF_POS_XERR_SUM]   = xerr_sum_reg;
            end
            `ISRF_OFF_COUNT_W7LO: begin
               for (int k = 3; k < 7; k++) begin
                  rdat_next[8*(k-3) +: 8] = slot_bytes(store_q, k);
               end
            end
            `ISRF_OFF_COUNT_W7HI: begin
               rdat_next[7:0] = slot_bytes(store_q, 7);
            end
            `ISRF_OFF_COUNT_W5HI: begin
               for (int k = 0; k < 3; k++) begin
                  rdat_next[`ISRF_POS_W5_SLOT0 + 8*k +: 8] =
                     slot_bytes(store_q, k);
               end
            end
            `ISRF_OFF_IRQ_STATUS: rdat_next[3:0] = irq_sts_reg;
            `ISRF_OFF_IRQ_MASK:   rdat_next[3:0] = irq_msk_reg;
            default:              rdat_next = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register all state
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         ss_sel_reg     <= `ISRF_RST_SEL;
         cs_sel_reg     <= `ISRF_RST_SEL;
         dir_in_reg     <= 1'b0;
         frame_reg      <= `ISRF_RST_FRAME;
         issued_reg     <= 8'h00;
         irq_sts_reg    <= `ISRF_RST_IRQ;
         irq_msk_reg    <= `ISRF_RST_IRQ;
         babble_sum_reg <= 1'b0;
         xerr_sum_reg   <= 1'b0;
         ack_reg        <= 1'b0;
         rdat_reg       <= 32'h0000_0000;
         ss_iss_reg     <= 1'b0;
         cs_iss_reg     <= 1'b0;
         slot_reg       <= 3'h0;
         irq_reg        <= 1'b0;
      end else begin
         ss_sel_reg     <= ss_sel_next;
         cs_sel_reg     <= cs_sel_next;
         dir_in_reg     <= dir_in_next;
         frame_reg      <= frame_next;
         issued_reg     <= issued_next;
         irq_sts_reg    <= irq_sts_next;
         irq_msk_reg    <= irq_msk_next;
         babble_sum_reg <= babble_sum_next;
         xerr_sum_reg   <= xerr_sum_next;
         ack_reg        <= ack_next;
         rdat_reg       <= rdat_next;
         ss_iss_reg     <= ss_iss_next;
         cs_iss_reg     <= cs_iss_next;
         slot_reg       <= slot_next;
         irq_reg        <= irq_next;
      end
   end

   // outputs straight from flip-flops
   assign o_wb_dat     = rdat_reg;
   assign o_wb_ack     = ack_reg;
   assign o_ss_issue   = ss_iss_reg;
   assign o_cs_issue   = cs_iss_reg;
   assign o_issue_slot = slot_reg;
   assign o_irq        = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_count_overwrite: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      rec |=> slot_bytes(store_q, $past(i_result.slot)) ==
              $past(i_result.bytes))
      else $error("byte count not overwritten");

   a_slot_untouched: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      !rec |=> $stable(store_q))
      else $error("slot changed without a scheduled split");

   a_record_gated: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      (i_result_valid && !issued_reg[i_result.slot]) |=> $stable(store_q))
      else $error("unscheduled slot recorded");

   a_ss_clear_done: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      (i_result_valid && !i_result.is_complete && ss_sw_set == 8'h00)
      |=> !ss_sel_reg[$past(i_result.slot)])
      else $error("start split bit not cleared");

   a_cs_clear_done: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      (i_result_valid && i_result.is_complete && cs_sw_set == 8'h00)
      |=> !cs_sel_reg[$past(slot_reg)])
      else $error("complete split bit not cleared");

   a_ss_issue_slot: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      (i_uframe_tick && ss_sel_reg[i_tick.uframe] && frame_ok)
      |=> o_ss_issue && !o_cs_issue && o_issue_slot == $past(i_tick.uframe))
      else $error("start split not issued in its microframe");

   a_cs_in_only: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      o_cs_issue |-> $past(dir_in_reg) && $past(cs_sel_reg[i_tick.uframe]))
      else $error("complete split issued without IN or select");

   a_babble_in_only: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      (rec && !dir_in_reg) |=>
      !slot_flag(store_q, $past(i_result.slot), `ISRF_STS_BABBLE))
      else $error("babble set for OUT");

   a_underrun_out: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      (rec && dir_in_reg) |=>
      !slot_flag(store_q, $past(i_result.slot), `ISRF_STS_UNDERRUN))
      else $error("underrun set for IN");

   a_xerr_kept: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      rec |=> slot_flag(store_q, $past(i_result.slot), `ISRF_STS_XERR)
              == $past(i_result.xerr))
      else $error("transaction error bit wrong");

   a_summary_flags: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      ##1 (babble_sum_reg == $past(|any_babble)) &&
          (xerr_sum_reg == $past(|any_xerr)))
      else $error("summary flags out of step");

   a_ack_single: assert property (@(posedge i_ref_clk)
      disable iff (!i_resetn)
      (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack ##1 !o_wb_ack)
      else $error("ack not a single cycle");

endmodule

// ==== testbench/isrf_engine_model.sv ====
// stand-in for the transfer engine and hub answering each issued split
// assumes issue pulses and slot come from the block on i_ref_clk
module isrf_engine_model (
   input  wire logic              i_ref_clk,
   input  wire logic              i_ss_issue,
   input  wire logic              i_cs_issue,
   input  wire logic [2:0]        i_slot,
   input  wire logic              i_dir_in,
   input  wire logic [7:0]        i_bytes,
   input  wire logic [2:0]        i_flags,
   input  wire logic [3:0]        i_delay,
   output logic                   o_valid,
   output isrf_pkg::isrf_result_t o_result
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] start_slot;

   ////////////////////////////////////////////////////////////////////////
   // quiet outputs at time zero
   initial begin
      o_valid = 1'b0;
      o_result = '0;
      start_slot = 3'h0;
   end

   // one result pulse after the set delay, then scrambled stale lines
   task automatic send(input logic [2:0] s, input logic c,
                       input logic [7:0] b, input logic [2:0] f);
      repeat (i_delay) @(posedge i_ref_clk);
      o_valid <= 1'b1;
      o_result <= '{slot: s, is_complete: c, bytes: b,
                    xerr: f[0], babble: f[1], underrun: f[2]};
      @(posedge i_ref_clk);
      o_valid <= 1'b0;
      o_result <= ~o_result;  // lines not held after the pulse
   endtask

   // start answers carry data for OUT only; complete answers follow start
   initial forever begin
      @(posedge i_ref_clk);
      if (i_ss_issue === 1'b1) begin
         start_slot = i_slot;
         if (i_dir_in === 1'b1)
            send(i_slot, 1'b0, 8'h00, 3'h0);
         else
            send(i_slot, 1'b0, i_bytes, i_flags);
      end else if (i_cs_issue === 1'b1)
         send(start_slot, 1'b1, i_bytes, i_flags);
   end
endmodule

// ==== testbench/isrf_bench.sv ====
// self-checking bench for the split result block over classic wishbone
// assumes a 50 MHz clock and the engine stand-in on the result port
module isrf_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic                   clk, resetn, cyc, stb, we, tk, ack, rv;
   logic                   ss, cs, irq, dir_m;
   logic [7:0]             adr, pb, ss_m, cs_m;
   logic [3:0]             sel, pd, irq_m, mask_m;
   logic [31:0]            wdat, rdat;
   logic [2:0]             islot, pf;
   logic [4:0]             frm_m;
   logic [7:0]             cnt [8];
   logic [2:0]             sts [8];
   isrf_pkg::isrf_tick_t   tick;
   isrf_pkg::isrf_result_t res;
   logic [31:0]            eq [$];
   logic [31:0]            iq [$];
   string                  nq [$];
   int                     err_count, compares, cycles;

   isrf_top uut (.i_ref_clk(clk), .i_resetn(resetn), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_uframe_tick(tk), .i_tick(tick), .i_result_valid(rv),
      .i_result(res), .o_ss_issue(ss), .o_cs_issue(cs),
      .o_issue_slot(islot), .o_irq(irq));

   isrf_engine_model eng (.i_ref_clk(clk), .i_ss_issue(ss),
      .i_cs_issue(cs), .i_slot(islot), .i_dir_in(dir_m), .i_bytes(pb),
      .i_flags(pf), .i_delay(pd), .o_valid(rv), .o_result(res));

   ////////////////////////////////////////////////////////////////////////
   // 20 ns clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // comparison with count and report
   task automatic check(input string n, input logic [31:0] s,
                        input logic [31:0] e);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask

   // counts line, verdict, end of run
   task automatic results();
      check("issues left", 32'(iq.size()), 32'h0);
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         results();
      end
   end

   // read data taken at the ack edge against the oldest note
   always @(posedge clk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (eq.size() > 0)
            check(nq.pop_front(), rdat, eq.pop_front());
         else
            check("spare ack", 32'h1, 32'h0);
      end
   end

   // issue pulses against the oldest scheduled note
   always @(posedge clk) begin
      if ((ss | cs) === 1'b1) begin
         if (iq.size() > 0)
            check("issue", 32'({ss, cs, islot}), iq.pop_front());
         else
            check("issue", 32'({ss, cs, islot}), 32'h0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // expected register word from the bench's own model
   function automatic logic [31:0] word(input logic [7:0] a);
      logic [31:0] w;
      logic        b, x;
      w = 32'h0;
      b = 1'b0;
      x = 1'b0;
      for (int k = 0; k < 8; k++) begin
         b |= sts[k][1];
         x |= sts[k][0];
      end
      case (a)
         8'h00: w = {16'h0, cs_m, ss_m};
         8'h04: w = {19'h0, frm_m, 7'h0, dir_m};
         8'h08: for (int k = 0; k < 8; k++) w[8+3*k +: 3] = sts[k];
         8'h0C: w = {2'h0, b, x, 28'h0};
         8'h10: w = {cnt[6], cnt[5], cnt[4], cnt[3]};
         8'h14: w = {24'h0, cnt[7]};
         8'h18: w = {cnt[2], cnt[1], cnt[0], 8'h0};
         8'h1C: w = {28'h0, irq_m};
         8'h20: w = {28'h0, mask_m};
         default: w = 32'h0;
      endcase
      return w;
   endfunction

   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // read with its expectation noted first; status read clears
   task automatic rd(input logic [7:0] a);
      eq.push_back(word(a));
      nq.push_back($sformatf("reg %h", a));
      if (a == 8'h1C)
         irq_m = 4'h0;
      wb(1'b0, a, 32'h0);
   endtask

   // whole map plus one unmapped place, then the interrupt line
   task automatic rdall();
      for (int a = 0; a <= 32; a += 4)
         rd(8'(a));
      rd(8'h40);
      check("irq clear", 32'(irq), 32'(|(irq_m & mask_m)));
   endtask

   // microframe tick pulse
   task automatic tick_at(input logic [2:0] u, input logic [4:0] f);
      @(posedge clk);
      tk <= 1'b1;
      tick.uframe <= u;
      tick.frame <= f;
      @(posedge clk);
      tk <= 1'b0;
   endtask

   // wait for the engine's result, then let summary settle
   task automatic wres();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rv !== 1'b1 && n < 40);
      if (n >= 40)
         check("result wait", 32'h1, 32'h0);
      repeat (3) @(posedge clk);
   endtask

   // recorded result in the model, flags masked by direction
   task automatic rec(input int s, input logic [2:0] f);
      cnt[s] = pb;
      sts[s] = dir_m ? {1'b0, f[1:0]} : {f[2], 1'b0, f[0]};
      irq_m |= {sts[s], 1'b1};
      check("irq", 32'(irq), 32'(|(irq_m & mask_m)));
   endtask

   // OUT start split in slot s with random count and delay
   task automatic op_out(input int s, input logic [2:0] f);
      pb <= 8'($urandom);
      pf <= f;
      pd <= 4'($urandom % 6);
      ss_m[s] = 1'b1;
      wb(1'b1, 8'h00, 32'h1 << s);
      iq.push_back({27'h0, 2'b10, 3'(s)});
      tick_at(3'(s), frm_m);
      wres();
      ss_m[s] = 1'b0;
      rec(s, f);
      rdall();
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {resetn, cyc, stb, we, tk, dir_m, ss_m, cs_m} = '0;
      {adr, sel, wdat, tick, pb, pf, pd, irq_m, mask_m, frm_m} = '0;
      for (int k = 0; k < 8; k++) begin
         cnt[k] = 8'h00;
         sts[k] = 3'h0;
      end
      void'($urandom(32'hF8AA4041));
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      rdall();
      frm_m = 5'h0B;
      wb(1'b1, 8'h04, {19'h0, frm_m, 8'h00});
      for (int s = 0; s < 8; s++) begin
         if (s == 4) begin
            mask_m = 4'hF;
            wb(1'b1, 8'h20, 32'hF);
         end
         op_out(s, 3'($urandom));
      end
      // IN: start in microframe 0, complete in microframe 2
      dir_m = 1'b1;
      wb(1'b1, 8'h04, {19'h0, frm_m, 8'h01});
      ss_m[0] = 1'b1;
      cs_m[2] = 1'b1;
      wb(1'b1, 8'h00, 32'h0401);
      wb(1'b1, 8'h00, 32'h0);
      rdall();
      pb <= 8'($urandom);
      pf <= 3'h7;
      iq.push_back({27'h0, 2'b10, 3'h0});
      tick_at(3'h0, frm_m);
      wres();
      ss_m[0] = 1'b0;
      iq.push_back({27'h0, 2'b01, 3'h2});
      tick_at(3'h2, frm_m);
      wres();
      cs_m[2] = 1'b0;
      rec(0, 3'h7);
      rdall();
      // wrong frame and an unsolicited result leave slot 5 alone
      dir_m = 1'b0;
      wb(1'b1, 8'h04, {19'h0, frm_m, 8'h00});
      ss_m[5] = 1'b1;
      cs_m[5] = 1'b1;
      wb(1'b1, 8'h00, 32'h2020);  // no complete split for OUT
      tick_at(3'h5, frm_m + 5'h01);
      eng.send(3'h5, 1'b0, 8'hA5, 3'h7);
      repeat (3) @(posedge clk);
      ss_m[5] = 1'b0;
      rdall();
      op_out(0, 3'h7);
      results();
   end
endmodule
